// *** hdl/omv_gain_stage.sv ***
`timescale 1ns/1ps
module omv_gain_stage (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic commit_i,
   input wire logic zc_en_i,
   input wire logic [5:0] stored_level_i,
   input wire logic [5:0] reset_level_i,
   input wire logic zc_detect_i,
   input wire logic timeout_tick_i,
   output logic [5:0] level_o,
   output logic pending_o
);
   omv_pkg::omv_zc_state_t state_reg, state_next;
   logic [5:0] level_reg;
   wire waiting = (state_reg == omv_pkg::OMV_ST_WAIT);
   // a change of zero-cross enable while waiting releases the held update
   wire release_w = waiting && (zc_detect_i || timeout_tick_i || !zc_en_i);
   wire apply_now = (commit_i && !zc_en_i) || release_w;
   always_comb begin
      case (state_reg)
         omv_pkg::OMV_ST_IDLE: state_next = (commit_i && zc_en_i && !zc_detect_i)
            ? omv_pkg::OMV_ST_WAIT : omv_pkg::OMV_ST_IDLE;
         omv_pkg::OMV_ST_WAIT: state_next = release_w ? omv_pkg::OMV_ST_IDLE : omv_pkg::OMV_ST_WAIT;
         default: state_next = omv_pkg::OMV_ST_IDLE;
      endcase
   end
   wire apply_w = apply_now || (commit_i && zc_en_i && zc_detect_i);
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= omv_pkg::OMV_ST_IDLE;
         // power-on level is a tied constant from the register bank
         level_reg <= reset_level_i;
      end else begin
         state_reg <= state_next;
         if (apply_w) begin
            level_reg <= stored_level_i;
         end
      end
   end
   assign level_o = level_reg;
   assign pending_o = waiting;
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   direct_apply_a: assert property (commit_i && !zc_en_i |=> level_o == $past(stored_level_i))
      else $error("direct update not applied");
   zc_defer_a: assert property (commit_i && zc_en_i && !zc_detect_i && !waiting
      |=> $stable(level_o) && pending_o)
      else $error("zero-cross update not deferred");
   zc_release_a: assert property (waiting && zc_detect_i |=> !pending_o && level_o == $past(stored_level_i))
      else $error("zero crossing did not apply volume");
   timeout_apply_a: assert property (waiting && timeout_tick_i
      |=> !pending_o && level_o == $past(stored_level_i))
      else $error("timeout did not apply volume");
   store_only_a: assert property (!commit_i && !waiting |=> $stable(level_o))
      else $error("gain changed without update");
endmodule : omv_gain_stage

// *** hdl/omv_output_mix_volume_ctrl.sv ***
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "omv_defs.svh"
// Function
// - routing register holds four right speaker mixer source enables, 1 passes, reset 0
// - bits 5:2 give each right speaker source 0dB or -3dB, reset 0dB
// - bits 1:0 set speaker mixer level 0, -6, -12dB or mute, reset mute
// - six output gain stages, each with its own register, applied in left/right pairs by one update bit
// - with zero-cross enabled a pending volume waits for a zero crossing
// - with zero-cross enabled the timeout tick applies a still pending volume
// - a volume write without update bit stores but leaves applied gain alone, except clearing zero-cross while pending applies it
// - update bit 8 in either mixer output register applies both volumes
// - bit 7 of each mixer output register enables zero-cross, reset off
// - bit 6 of each mixer output register is active low mute, reset unmuted
// - bits 5:0 hold six-bit volume, reset 39h for 0dB
// - headphone stage input selects output mixer by default, converter when set
// - headphone update bit applies both headphone volumes, otherwise only stores
module omv_output_mix_volume_ctrl #(
   parameter int unsigned TO_SLOW_CYC = (`OMV_TO_SLOW_US * 1000) / `OMV_CLK_PERIOD_NS,
   parameter int unsigned TO_FAST_CYC = (`OMV_TO_FAST_US * 1000) / `OMV_CLK_PERIOD_NS
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic [11:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [11:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [5:0] zero_cross_i,
   output omv_pkg::omv_stage_t [5:0] stage_gain_o,
   output omv_pkg::omv_spk_mix_t right_speaker_mixer_o,
   output logic [1:0] headphone_direct_select_o
);
   // stage order: 0/1 mixer out L/R, 2/3 headphone L/R, 4/5 speaker L/R
   function automatic logic [2:0] stage_of(input logic [7:0] idx);
      case (idx)
         `OMV_IDX_MIXL: stage_of = 3'h0;
         `OMV_IDX_MIXR: stage_of = 3'h1;
         `OMV_IDX_HPL: stage_of = 3'h2;
         `OMV_IDX_HPR: stage_of = 3'h3;
         `OMV_IDX_SPKL: stage_of = 3'h4;
         `OMV_IDX_SPKR: stage_of = 3'h5;
         default: stage_of = `OMV_NONE;
      endcase
   endfunction : stage_of

   ////////////////////////////////////////////////////////////////
   // write channel: address and data may arrive in either order
   logic aw_full_reg;
   logic [11:0] aw_addr_reg;
   logic w_full_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;

   assign s_axi_awready_o = !aw_full_reg;
   assign s_axi_wready_o = !w_full_reg;
   wire aw_take = s_axi_awvalid_i && !aw_full_reg;
   wire w_take = s_axi_wvalid_i && !w_full_reg;
   wire aw_have = aw_full_reg || aw_take;
   wire w_have = w_full_reg || w_take;
   wire do_write = aw_have && w_have && !bvalid_reg;
   wire [11:0] wr_addr = aw_full_reg ? aw_addr_reg : s_axi_awaddr_i;
   wire [31:0] wr_data = w_full_reg ? w_data_reg : s_axi_wdata_i;
   wire [3:0] wr_strb = w_full_reg ? w_strb_reg : s_axi_wstrb_i;
   wire [7:0] wr_idx = wr_addr[9:2];
   wire [2:0] wr_stage = stage_of(wr_idx);
   wire wr_lo = wr_strb[0];
   wire wr_hi = wr_strb[1];

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else begin
         if (do_write) begin
            aw_full_reg <= 1'b0;
         end else if (aw_take) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_i;
         end
         if (do_write) begin
            w_full_reg <= 1'b0;
         end else if (w_take) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i;
            w_strb_reg <= s_axi_wstrb_i;
         end
      end
   end

   wire wr_mapped = (wr_stage != `OMV_NONE) || (wr_idx == `OMV_IDX_ATT) || (wr_idx == `OMV_IDX_ROUTE)
      || (wr_idx == `OMV_IDX_HPSELL) || (wr_idx == `OMV_IDX_HPSELR) || (wr_idx == `OMV_IDX_TOCTL)
      || (wr_idx == `OMV_IDX_STAT);
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `OMV_RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_mapped ? `OMV_RESP_OKAY : `OMV_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid_reg <= 1'b0;
      end
   end
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;

   ////////////////////////////////////////////////////////////////
   // control registers
   logic [7:0] gain_reg [`OMV_NSTAGE];
   logic [7:0] route_reg;
   logic [5:0] att_reg;
   logic [1:0] hpsel_reg;
   logic [1:0] toctl_reg;
   logic [2:0] commit_reg;

   wire [2:0] commit_next;
   // the update bit is a strobe: it is never stored, so it reads back as zero
   wire wr_commit = do_write && wr_hi && wr_data[`OMV_COMMIT_BIT] && (wr_stage != `OMV_NONE);
   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++) begin : g_pair
         assign commit_next[gp] = wr_commit && (wr_stage[2:1] == 2'(gp));
      end
   endgenerate

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         route_reg <= 8'h00;
         att_reg <= `OMV_ATT_RST;
         hpsel_reg <= 2'h0;
         toctl_reg <= 2'h0;
         commit_reg <= 3'h0;
      end else begin
         // commit lags the write by one cycle, landing with the store, so the stage sees the new value
         commit_reg <= commit_next;
         if (do_write && wr_lo && wr_idx == `OMV_IDX_ROUTE) begin
            route_reg <= wr_data[7:0] & `OMV_ROUTE_MASK;
         end
         if (do_write && wr_lo && wr_idx == `OMV_IDX_ATT) begin
            att_reg <= wr_data[5:0];
         end
         if (do_write && wr_hi && wr_idx == `OMV_IDX_HPSELL) begin
            hpsel_reg[0] <= wr_data[`OMV_HPSEL_BIT];
         end
         if (do_write && wr_hi && wr_idx == `OMV_IDX_HPSELR) begin
            hpsel_reg[1] <= wr_data[`OMV_HPSEL_BIT];
         end
         if (do_write && wr_lo && wr_idx == `OMV_IDX_TOCTL) begin
            toctl_reg <= wr_data[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // timeout tick: runs only while enabled; free running, as a divided clock would
   logic [19:0] to_cnt_reg;
   wire to_en = toctl_reg[`OMV_TO_EN_BIT];
   wire [19:0] to_last = toctl_reg[`OMV_TO_RATE_BIT] ? 20'(TO_FAST_CYC - 1) : 20'(TO_SLOW_CYC - 1);
   wire to_tick = to_en && (to_cnt_reg >= to_last);
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || !to_en || to_tick) begin
         to_cnt_reg <= 20'h00000;
      end else begin
         to_cnt_reg <= to_cnt_reg + 20'h00001;
      end
   end

   ////////////////////////////////////////////////////////////////
   // six gain stages
   logic [5:0] pending;
   logic [5:0] applied_level [`OMV_NSTAGE];
   genvar gs;
   generate
      for (gs = 0; gs < `OMV_NSTAGE; gs++) begin : g_stage
         localparam logic [2:0] SIDX = 3'(gs);
         localparam logic [7:0] RST = (gs == 2 || gs == 3) ? `OMV_HP_GAIN_RST : `OMV_GAIN_RST;
         always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
               gain_reg[gs] <= RST;
            end else if (do_write && wr_lo && wr_stage == SIDX) begin
               gain_reg[gs] <= wr_data[7:0];
            end
         end
         omv_gain_stage u_stage (
            .ref_clk_i(ref_clk_i),
            .sys_rst_i(sys_rst_i),
            .commit_i(commit_reg[gs / 2]),
            .zc_en_i(gain_reg[gs][`OMV_ZC_BIT]),
            .stored_level_i(gain_reg[gs][5:0]),
            .reset_level_i(RST[5:0]),
            .zc_detect_i(zero_cross_i[gs]),
            .timeout_tick_i(to_tick),
            .level_o(applied_level[gs]),
            .pending_o(pending[gs])
         );
         assign stage_gain_o[gs].level = applied_level[gs];
         // mute acts at once; only the volume waits for an update
         assign stage_gain_o[gs].unmute = gain_reg[gs][`OMV_UNMUTE_BIT];
      end
   endgenerate

   assign right_speaker_mixer_o.route = {route_reg[6], route_reg[4], route_reg[2], route_reg[0]};
   assign right_speaker_mixer_o.fine_atten = att_reg[5:2];
   wire spk_muted = (att_reg[1:0] == `OMV_LVL_MUTE);
   assign right_speaker_mixer_o.mute = spk_muted;
   assign right_speaker_mixer_o.atten_6db_steps = spk_muted ? 2'h0 : att_reg[1:0];
   assign headphone_direct_select_o = hpsel_reg;

   ////////////////////////////////////////////////////////////////
   // read channel: one cycle to answer
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   wire ar_take = s_axi_arvalid_i && !rvalid_reg;
   wire [7:0] rd_idx = s_axi_araddr_i[9:2];
   wire [2:0] rd_stage = stage_of(rd_idx);
   wire [7:0] rd_gain = (rd_stage == `OMV_NONE) ? 8'h00 : gain_reg[rd_stage];
   wire [31:0] rd_other =
      (rd_idx == `OMV_IDX_ROUTE) ? {24'h000000, route_reg} :
      (rd_idx == `OMV_IDX_ATT) ? {26'h0000000, att_reg} :
      (rd_idx == `OMV_IDX_HPSELL) ? {23'h000000, hpsel_reg[0], 8'h00} :
      (rd_idx == `OMV_IDX_HPSELR) ? {23'h000000, hpsel_reg[1], 8'h00} :
      (rd_idx == `OMV_IDX_TOCTL) ? {30'h00000000, toctl_reg} :
      (rd_idx == `OMV_IDX_STAT) ? {26'h0000000, pending} : 32'h00000000;
   wire rd_mapped = (rd_stage != `OMV_NONE) || (rd_idx == `OMV_IDX_ROUTE) || (rd_idx == `OMV_IDX_ATT)
      || (rd_idx == `OMV_IDX_HPSELL) || (rd_idx == `OMV_IDX_HPSELR) || (rd_idx == `OMV_IDX_TOCTL)
      || (rd_idx == `OMV_IDX_STAT);
   wire [31:0] rd_word = (rd_stage != `OMV_NONE) ? {24'h000000, rd_gain} : rd_other;

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `OMV_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_mapped ? `OMV_RESP_OKAY : `OMV_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign s_axi_arready_o = !rvalid_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign s_axi_rresp_o = rresp_reg;

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   route_store_a: assert property (do_write && wr_lo && wr_idx == `OMV_IDX_ROUTE
      |=> right_speaker_mixer_o.route == {$past(wr_data[6]), $past(wr_data[4]), $past(wr_data[2]),
      $past(wr_data[0])})
      else $error("routing bits not stored");
   fine_atten_a: assert property (do_write && wr_lo && wr_idx == `OMV_IDX_ATT
      |=> right_speaker_mixer_o.fine_atten == $past(wr_data[5:2]))
      else $error("fine attenuation not stored");
   spk_mute_a: assert property (right_speaker_mixer_o.mute == (att_reg[1:0] == `OMV_LVL_MUTE))
      else $error("speaker mixer mute decode wrong");
   pair_commit_a: assert property (wr_commit |=> commit_reg[$past(wr_stage[2:1])])
      else $error("update bit did not commit pair");
   no_commit_a: assert property (do_write && !(wr_hi && wr_data[`OMV_COMMIT_BIT]) |=> commit_reg == 3'h0)
      else $error("commit without update bit");
   hp_commit_a: assert property (wr_commit && wr_stage[2:1] == 2'h1
      |=> ##1 (gain_reg[2][`OMV_ZC_BIT] || applied_level[2] == gain_reg[2][5:0])
      && (gain_reg[3][`OMV_ZC_BIT] || applied_level[3] == gain_reg[3][5:0]))
      else $error("headphone volumes not applied together");
   zc_bit_a: assert property (do_write && wr_lo && wr_stage == 3'h0
      |=> gain_reg[0][`OMV_ZC_BIT] == $past(wr_data[`OMV_ZC_BIT]))
      else $error("zero-cross enable not stored");
   mute_path_a: assert property (do_write && wr_lo && wr_stage == 3'h1
      |=> stage_gain_o[1].unmute == $past(wr_data[`OMV_UNMUTE_BIT]))
      else $error("mute bit not applied");
   hp_select_a: assert property (do_write && wr_hi && wr_idx == `OMV_IDX_HPSELR
      |=> headphone_direct_select_o[1] == $past(wr_data[`OMV_HPSEL_BIT]))
      else $error("headphone source select not stored");
   tick_gate_a: assert property (!to_en |=> to_cnt_reg == 20'h00000)
      else $error("timeout tick while disabled");
   write_answer_a: assert property (do_write |=> s_axi_bvalid_o)
      else $error("write not answered");

   ////////////////////////////////////////////////////////////////
   // register fields, pair commits, zero-cross release and timeout count; the zero-cross deferral is guarded inside each stage
   level_store_a: assert property (do_write && wr_lo && wr_stage == 3'h1
      |=> gain_reg[1][5:0] == $past(wr_data[5:0]))
      else $error("volume field not stored");
   spk_level_a: assert property (do_write && wr_lo && wr_stage == 3'h5
      |=> gain_reg[5][5:0] == $past(wr_data[5:0]))
      else $error("speaker volume not stored");
   route_mask_a: assert property ((route_reg & ~`OMV_ROUTE_MASK) == 8'h00)
      else $error("left routing bit stored");
   route_hold_a: assert property (!(do_write && wr_lo && wr_idx == `OMV_IDX_ROUTE) |=> $stable(route_reg))
      else $error("routing changed without write");
   att_hold_a: assert property (!(do_write && wr_lo && wr_idx == `OMV_IDX_ATT) |=> $stable(att_reg))
      else $error("attenuation changed without write");
   mute_steps_a: assert property (right_speaker_mixer_o.mute |-> right_speaker_mixer_o.atten_6db_steps == 2'h0)
      else $error("muted speaker mixer shows a level");
   stray_commit_a: assert property (commit_reg != 3'h0 |-> $past(wr_commit))
      else $error("commit without a write");
   mix_pair_a: assert property (commit_reg[0] && !gain_reg[0][`OMV_ZC_BIT] && !gain_reg[1][`OMV_ZC_BIT]
      |=> applied_level[0] == $past(gain_reg[0][5:0]) && applied_level[1] == $past(gain_reg[1][5:0]))
      else $error("mixer output pair not applied together");
   spk_pair_a: assert property (commit_reg[2] && !gain_reg[4][`OMV_ZC_BIT] && !gain_reg[5][`OMV_ZC_BIT]
      |=> applied_level[4] == $past(gain_reg[4][5:0]) && applied_level[5] == $past(gain_reg[5][5:0]))
      else $error("speaker pair not applied together");
   gain_hold_a: assert property (!(do_write && wr_lo && wr_stage == 3'h4) |=> $stable(gain_reg[4]))
      else $error("speaker register changed without write");
   hpsel_hold_a: assert property (!(do_write && wr_hi && wr_idx == `OMV_IDX_HPSELL)
      && !(do_write && wr_hi && wr_idx == `OMV_IDX_HPSELR) |=> $stable(headphone_direct_select_o))
      else $error("headphone select changed without write");
   hp_unmute_a: assert property (do_write && wr_lo && wr_stage == 3'h3
      |=> stage_gain_o[3].unmute == $past(wr_data[`OMV_UNMUTE_BIT]))
      else $error("headphone mute bit not applied");
   spk_unmute_a: assert property (do_write && wr_lo && wr_stage == 3'h5
      |=> stage_gain_o[5].unmute == $past(wr_data[`OMV_UNMUTE_BIT]))
      else $error("speaker mute bit not applied");
   zc_right_a: assert property (do_write && wr_lo && wr_stage == 3'h1
      |=> gain_reg[1][`OMV_ZC_BIT] == $past(wr_data[`OMV_ZC_BIT]))
      else $error("right zero-cross enable not stored");
   hp_zc_a: assert property (do_write && wr_lo && wr_stage == 3'h2
      |=> gain_reg[2][`OMV_ZC_BIT] == $past(wr_data[`OMV_ZC_BIT]))
      else $error("headphone zero-cross enable not stored");
   zc_off_release_a: assert property (pending[1] && !gain_reg[1][`OMV_ZC_BIT] |=> !pending[1])
      else $error("held update kept after zero-cross off");
   to_count_a: assert property (to_en && !to_tick |=> to_cnt_reg == $past(to_cnt_reg) + 20'h00001)
      else $error("timeout counter did not advance");
endmodule : omv_output_mix_volume_ctrl

// *** include/omv_defs.svh ***
`ifndef OMV_DEFS_SVH
`define OMV_DEFS_SVH
`define OMV_CLK_PERIOD_NS 8
`define OMV_TO_SLOW_US 4000
`define OMV_TO_FAST_US 1000
`define OMV_NSTAGE 6
`define OMV_NONE 3'h7
`define OMV_IDX_HPL 8'h1c
`define OMV_IDX_HPR 8'h1d
`define OMV_IDX_MIXL 8'h20
`define OMV_IDX_MIXR 8'h21
`define OMV_IDX_ATT 8'h22
`define OMV_IDX_SPKL 8'h26
`define OMV_IDX_SPKR 8'h27
`define OMV_IDX_HPSELL 8'h2d
`define OMV_IDX_HPSELR 8'h2e
`define OMV_IDX_ROUTE 8'h36
`define OMV_IDX_TOCTL 8'h40
`define OMV_IDX_STAT 8'h41
`define OMV_COMMIT_BIT 8
`define OMV_ZC_BIT 7
`define OMV_UNMUTE_BIT 6
`define OMV_HPSEL_BIT 8
`define OMV_GAIN_RST 8'h79
`define OMV_HP_GAIN_RST 8'h6d
`define OMV_ROUTE_MASK 8'h55
`define OMV_ATT_RST 6'h03
`define OMV_LVL_MUTE 2'h3
`define OMV_TO_EN_BIT 0
`define OMV_TO_RATE_BIT 1
`define OMV_RESP_OKAY 2'h0
`define OMV_RESP_SLVERR 2'h2
`endif

// *** include/omv_pkg.sv ***
package omv_pkg;
   typedef enum logic [1:0] {
      OMV_ST_IDLE = 2'b01,
      OMV_ST_WAIT = 2'b10
   } omv_zc_state_t;
   typedef struct packed {
      logic unmute;
      logic [5:0] level;
   } omv_stage_t;
   typedef struct packed {
      logic [3:0] route;
      logic [3:0] fine_atten;
      logic [1:0] atten_6db_steps;
      logic mute;
   } omv_spk_mix_t;
endpackage : omv_pkg

// *** test/tb.sv ***
`timescale 1ns/1ps
`include "omv_defs.svh"
module tb;
   logic ref_clk_i;
   logic sys_rst_i;
   logic [11:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rr;
   logic [5:0] zc;
   omv_pkg::omv_stage_t [5:0] gain;
   omv_pkg::omv_spk_mix_t spk;
   logic [1:0] hpsel;
   int error_cnt = 0;
   int n_checks = 0;
   int t;

   // short timeout counts keep the run small: fast 8 cycles, slow 20
   omv_output_mix_volume_ctrl #(.TO_SLOW_CYC(20), .TO_FAST_CYC(8)) dut (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .zero_cross_i(zc), .stage_gain_o(gain), .right_speaker_mixer_o(spk), .headphone_direct_select_o(hpsel)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic results();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask : settle

   // ready is sampled at the falling edge; it only moves on rising edges
   task automatic axi_wr(input logic [7:0] idx, input logic [8:0] d, input logic [1:0] er);
      logic a_ok, w_ok, a_hit, w_hit;
      a_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge ref_clk_i);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {23'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a_ok && w_ok)) begin
         @(negedge ref_clk_i);
         a_hit = awready && !a_ok;
         w_hit = wready && !w_ok;
         @(posedge ref_clk_i);
         if (a_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
         a_ok = a_ok | a_hit;
         w_ok = w_ok | w_hit;
      end
      @(negedge ref_clk_i);
      while (bvalid !== 1'b1) begin
         @(negedge ref_clk_i);
      end
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge ref_clk_i);
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk_i);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(negedge ref_clk_i);
      while (arready !== 1'b1) begin
         @(negedge ref_clk_i);
      end
      @(posedge ref_clk_i);
      arvalid <= 1'b0;
      @(negedge ref_clk_i);
      while (rvalid !== 1'b1) begin
         @(negedge ref_clk_i);
      end
      d = rdata;
      r = rresp;
      @(posedge ref_clk_i);
      rready <= 1'b0;
   endtask : axi_rd

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      axi_rd(idx, rd, rr);
      chk(rd, exp);
      chk({30'h0, rr}, 32'h0);
   endtask : rdchk

   task automatic gchk(input int i, input logic [6:0] exp);
      chk({25'h0, gain[i]}, {25'h0, exp});
   endtask : gchk

   ////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      error_cnt++;
      results();
   end

   initial begin
      sys_rst_i = 1'b1;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hf;
      zc = 6'h00;
      repeat (20) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      settle(0);
      rdchk(`OMV_IDX_MIXL, 32'h79);
      rdchk(`OMV_IDX_MIXR, 32'h79);
      rdchk(`OMV_IDX_ATT, 32'h03);
      rdchk(`OMV_IDX_ROUTE, 32'h00);
      gchk(0, 7'h79);
      gchk(3, 7'h6d);
      chk({21'h0, spk}, 32'h1);
      chk({30'h0, hpsel}, 32'h0);
      // store without update on both channels, then update from the left channel
      axi_wr(`OMV_IDX_MIXL, 9'h050, `OMV_RESP_OKAY);
      settle(2);
      gchk(0, 7'h79);
      rdchk(`OMV_IDX_MIXL, 32'h50);
      axi_wr(`OMV_IDX_MIXR, 9'h060, `OMV_RESP_OKAY);
      axi_wr(`OMV_IDX_MIXL, 9'h150, `OMV_RESP_OKAY);
      settle(2);
      gchk(0, 7'h50);
      gchk(1, 7'h60);
      gchk(4, 7'h79);
      rdchk(`OMV_IDX_MIXL, 32'h50);
      axi_wr(`OMV_IDX_MIXL, 9'h010, `OMV_RESP_OKAY);
      settle(2);
      gchk(0, 7'h10);
      // right channel waits for its own zero crossing, left applies now
      axi_wr(`OMV_IDX_MIXR, 9'h0c5, `OMV_RESP_OKAY);
      axi_wr(`OMV_IDX_MIXL, 9'h151, `OMV_RESP_OKAY);
      settle(10);
      gchk(0, 7'h51);
      gchk(1, 7'h60);
      rdchk(`OMV_IDX_STAT, 32'h02);
      @(posedge ref_clk_i);
      zc <= 6'h02;
      @(posedge ref_clk_i);
      zc <= 6'h00;
      settle(2);
      gchk(1, 7'h45);
      // no crossing: fast timeout tick applies the pending value
      axi_wr(`OMV_IDX_TOCTL, 9'h003, `OMV_RESP_OKAY);
      axi_wr(`OMV_IDX_MIXR, 9'h1c7, `OMV_RESP_OKAY);
      t = 0;
      while (gain[1].level !== 6'h07 && t < 40) begin
         @(negedge ref_clk_i);
         t++;
      end
      gchk(1, 7'h47);
      axi_wr(`OMV_IDX_TOCTL, 9'h000, `OMV_RESP_OKAY);
      axi_wr(`OMV_IDX_SPKR, 9'h02a, `OMV_RESP_OKAY);
      axi_wr(`OMV_IDX_SPKL, 9'h101, `OMV_RESP_OKAY);
      settle(2);
      gchk(4, 7'h01);
      gchk(5, 7'h2a);
      gchk(0, 7'h51);
      // lane 1 carries only the update bit, lane 0 the stored fields
      @(posedge ref_clk_i);
      wstrb <= 4'h2;
      axi_wr(`OMV_IDX_SPKR, 9'h1ff, `OMV_RESP_OKAY);
      wstrb <= 4'h1;
      axi_wr(`OMV_IDX_SPKL, 9'h17f, `OMV_RESP_OKAY);
      wstrb <= 4'hf;
      settle(2);
      gchk(4, 7'h41);
      gchk(5, 7'h2a);
      rdchk(`OMV_IDX_SPKR, 32'h2a);
      rdchk(`OMV_IDX_SPKL, 32'h7f);
      axi_wr(`OMV_IDX_HPR, 9'h04b, `OMV_RESP_OKAY);
      settle(2);
      gchk(3, 7'h6d);
      axi_wr(`OMV_IDX_HPL, 9'h14c, `OMV_RESP_OKAY);
      settle(2);
      gchk(2, 7'h4c);
      gchk(3, 7'h4b);
      axi_wr(`OMV_IDX_HPSELL, 9'h100, `OMV_RESP_OKAY);
      settle(1);
      chk({30'h0, hpsel}, 32'h1);
      axi_wr(`OMV_IDX_HPSELR, 9'h100, `OMV_RESP_OKAY);
      settle(1);
      chk({30'h0, hpsel}, 32'h3);
      // route bits sit on even positions; odd ones belong to the left mixer
      // mixer paths change here only because no stage carries signal in this bench
      axi_wr(`OMV_IDX_ROUTE, 9'h0ff, `OMV_RESP_OKAY);
      rdchk(`OMV_IDX_ROUTE, 32'h55);
      chk({28'h0, spk.route}, 32'hf);
      axi_wr(`OMV_IDX_ROUTE, 9'h010, `OMV_RESP_OKAY);
      settle(1);
      chk({28'h0, spk.route}, 32'h4);
      for (int l = 0; l < 4; l++) begin
         axi_wr(`OMV_IDX_ATT, {3'h0, 6'h28 | 6'(l)}, `OMV_RESP_OKAY);
         rdchk(`OMV_IDX_ATT, 32'h28 | l);
         chk({21'h0, spk}, {21'h0, 4'h4, 4'ha, (l == 3) ? 2'h0 : 2'(l), l == 3});
      end
      axi_wr(8'h3f, 9'h1ff, `OMV_RESP_SLVERR);
      axi_rd(8'h3f, rd, rr);
      chk(rd, 32'h0);
      chk({30'h0, rr}, {30'h0, `OMV_RESP_SLVERR});
      results();
   end
endmodule : tb
